// ===== fcd_clkdiv.sv
// Flash timing clock divider producing one-cycle tick enables
`timescale 1ns/100ps
`default_nettype none
`include "fcd_params.svh"

module fcd_clkdiv #(
  parameter int DIV_W = `FCD_DIV_FIELD_W
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Settings
  input wire logic en,
  input wire logic presc,
  input wire logic [DIV_W-1:0] divisor,
  // Flash clock enable
  output logic tick
);

  typedef struct packed {
    logic [2:0] pre;
    logic [DIV_W-1:0] cnt;
    logic tick;
  } fcd_div_state_s;

  fcd_div_state_s s_r;
  fcd_div_state_s s_nxt;
  logic step;

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.tick = 1'b0;
    step = 1'b0;
    if (!en)
    begin
      s_nxt.pre = 3'h0;
      s_nxt.cnt = '0;
    end
    else
    begin
      // Bus clock or bus clock over eight feeds the divider
      step = !presc || (s_r.pre == `FCD_PRESC_LAST); // RULE_04
      s_nxt.pre = presc ? s_r.pre + 3'h1 : 3'h0; // RULE_04
      if (step)
      begin
        // Divide by divisor plus one
        if (s_r.cnt == divisor) // RULE_05
        begin
          s_nxt.cnt = '0;
          s_nxt.tick = 1'b1; // RULE_06
        end
        else
        begin
          s_nxt.cnt = s_r.cnt + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign tick = s_r.tick;

  sequence s_tick_seen;
    tick && en && !presc && (divisor == DIV_W'(3));
  endsequence

  a_tick_spacing: assert property ( // RULE_05
    @(posedge clk) disable iff (!rst_n)
    s_tick_seen |=> !tick ##1 !tick ##1 !tick ##1 tick)
  else $error("flash tick spacing differs from divisor plus one");

endmodule : fcd_clkdiv

`default_nettype wire

// ===== fcd_keycmp.sv
// Byte-serial comparator for the backdoor key entry
`timescale 1ns/100ps
`default_nettype none
`include "fcd_params.svh"

module fcd_keycmp #(
  parameter int KEY_BYTES = `FCD_KEY_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Entry stream
  input wire logic start,
  input wire logic wr,
  input wire logic [7:0] data,
  input wire logic [8*KEY_BYTES-1:0] key,
  // Result
  output logic match
);

  localparam int IDX_W = $clog2(KEY_BYTES) + 1;

  typedef struct packed {
    logic [IDX_W-1:0] idx;
    logic ok;
  } fcd_key_state_s;

  fcd_key_state_s s_r;
  fcd_key_state_s s_nxt;

  always_comb
  begin
    s_nxt = s_r;
    if (start)
    begin
      s_nxt.idx = '0;
      s_nxt.ok = 1'b1;
    end
    else if (wr)
    begin
      // Bytes are checked in ascending order, extras spoil the entry
      if (s_r.idx < IDX_W'(KEY_BYTES)) // RULE_13
      begin
        s_nxt.ok = s_r.ok && (data == key[8*s_r.idx +: 8]); // RULE_13
        s_nxt.idx = s_r.idx + 1'b1;
      end
      else
      begin
        s_nxt.ok = 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign match = s_r.ok && (s_r.idx == IDX_W'(KEY_BYTES));

endmodule : fcd_keycmp

`default_nettype wire

// ===== fcd_params.svh
// Register map, field positions and reset values of the flash clock block
`ifndef FCD_PARAMS_SVH
`define FCD_PARAMS_SVH

`define FCD_ADR_W 8
`define FCD_ADR_DIV 8'h00
`define FCD_ADR_OPT 8'h04
`define FCD_ADR_KDAT 8'h08
`define FCD_ADR_KCTL 8'h0c

`define FCD_DIV_LOADED_BIT 7
`define FCD_DIV_PRESC_BIT 6
`define FCD_DIV_FIELD_W 6

`define FCD_OPT_BACKDOOR_KEY_ENABLE_BIT 7
`define FCD_OPT_NORED_BIT 6
`define FCD_OPT_RESET 8'hff
`define FCD_SEC_UNSECURE 2'h2

`define FCD_KCTL_ACC_BIT 0
`define FCD_KCTL_SECURE_BIT 1
`define FCD_KCTL_MATCH_BIT 2

`define FCD_PRESC_LAST 3'h7
`define FCD_KEY_BYTES 8
`define FCD_PE_CNT_W 16

`endif

// ===== fcd_pkg.sv
// Types shared by the flash clock divider and options block
`default_nettype none
package fcd_pkg;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [7:0] adr;
    logic [3:0] sel;
    logic [31:0] dat;
  } fcd_wb_req_s;

  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } fcd_wb_rsp_s;

  typedef enum logic {
    FCD_PE_IDLE,
    FCD_PE_RUN
  } fcd_pe_e;

endpackage : fcd_pkg

`default_nettype wire

// ===== fcd_tb.sv
// Self-checking bench for the flash clock divider and options block
`timescale 1ns/100ps
`default_nettype none
`include "fcd_params.svh"

module testbench;
  import fcd_pkg::*;
  localparam logic [63:0] KEY = 64'h0f1e2d3c4b5a6978;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  fcd_wb_req_s wb_req = '0;
  fcd_wb_rsp_s wb_rsp;
  logic dbg = 1'b0;
  logic sfw = 1'b1;
  logic [7:0] nvo = 8'hbf;
  logic bc_done = 1'b0;
  logic bc_erased = 1'b0;
  logic pe_start = 1'b0;
  logic [15:0] pe_pulses = 16'h0000;
  logic mreq = 1'b0;
  logic mwe = 1'b0;
  logic munsec = 1'b0;
  logic [7:0] raw = 8'h5a;
  logic tick, busy, done, refused, mem_we, secure, vre, bke;
  logic [7:0] mrd;
  logic [31:0] q;
  logic rf;
  int nt, p, c;
  int n_mismatch = 0;
  int n_tests = 0;

  always #10 clk = ~clk;

  fcd_top i_dut (.clk(clk), .arst_n(arst_n), .wb_req(wb_req),
    .wb_rsp(wb_rsp), .bus_from_debug(dbg), .bus_from_secure(sfw),
    .nonvolatile_option_byte(nvo), .stored_backdoor_key(KEY),
    .blank_check_done(bc_done), .blank_all_erased(bc_erased),
    .pe_start(pe_start), .pe_pulses(pe_pulses), .flash_clk_tick(tick),
    .pe_busy(busy), .pe_done(done), .pe_refused(refused),
    .mem_req(mreq), .mem_we_req(mwe), .mem_from_unsecure(munsec),
    .mem_rdata_raw(raw), .mem_we(mem_we), .mem_rdata(mrd),
    .secure(secure), .vector_redirect_en(vre),
    .backdoor_key_enable(bke));

  task automatic give_verdict;
    if (n_mismatch == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic stop;
    n_mismatch++;
    give_verdict();
  endtask : stop

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk

  task automatic chk1(input logic g, input logic e);
    n_tests++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk1

  // Classic single cycle, held until ack, one idle cycle after
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    wb_req <= {2'b11, we, a, 4'h1, 24'h000000, d};
    // Ack and read data are taken at the edge that sees ack high
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_rsp.ack !== 1'b1 && n < 20);
    if (wb_rsp.ack !== 1'b1)
      stop();
    q = wb_rsp.dat;
    wb_req <= '0;
  endtask : wb

  task automatic rst(input logic [7:0] o);
    @(posedge clk);
    arst_n <= 1'b0;
    nvo <= o;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
  endtask : rst

  // Start a timing run and count flash ticks while busy
  task automatic pe(input logic [15:0] np);
    int n;
    @(posedge clk);
    pe_pulses <= np;
    pe_start <= 1'b1;
    @(posedge clk);
    pe_start <= 1'b0;
    #1;
    rf = refused;
    nt = 0;
    for (n = 0; n < 400 && rf !== 1'b1 && done !== 1'b1; n++)
    begin
      if (busy === 1'b1 && tick === 1'b1)
        nt++;
      @(posedge clk);
      #1;
    end
    if (n == 400)
      stop();
  endtask : pe

  // Bus clocks between two flash ticks
  task automatic per;
    int n;
    n = 0;
    do
    begin
      @(posedge clk);
      #1;
      n++;
    end
    while (tick !== 1'b1 && n < 300);
    p = 0;
    do
    begin
      @(posedge clk);
      #1;
      p++;
    end
    while (tick !== 1'b1 && p < 300);
    if (p >= 300)
      stop();
  endtask : per

  task automatic mem(input logic u, input logic pass);
    @(posedge clk);
    mreq <= 1'b1;
    mwe <= 1'b1;
    munsec <= u;
    #1;
    chk1(mem_we, pass);
    @(posedge clk);
    #1;
    chk(mrd, pass ? raw : 8'h00);
    @(posedge clk);
    mreq <= 1'b0;
    mwe <= 1'b0;
  endtask : mem

  task automatic key(input logic s, input logic d, input logic [63:0] k);
    int i;
    @(posedge clk);
    sfw <= s;
    dbg <= d;
    wb(1'b1, `FCD_ADR_KCTL, 8'h01);
    for (i = 0; i < 8; i++)
      wb(1'b1, `FCD_ADR_KDAT, k[8*i +: 8]);
    wb(1'b1, `FCD_ADR_KCTL, 8'h00);
    @(posedge clk);
    #1;
  endtask : key

  task automatic blank(input logic e);
    @(posedge clk);
    bc_done <= 1'b1;
    bc_erased <= e;
    @(posedge clk);
    bc_done <= 1'b0;
    @(posedge clk);
    #1;
  endtask : blank

  initial
  begin
    rst(8'hbf);
    chk1(secure, 1'b1);
    chk1(bke, 1'b1);
    chk1(vre, 1'b1);
    wb(1'b1, `FCD_ADR_OPT, 8'h00);
    wb(1'b0, `FCD_ADR_OPT, 8'h00);
    chk(q, 32'h00000083);
    wb(1'b0, 8'h10, 8'h00);
    chk(q, 32'h00000000);
    pe(16'h0003);
    chk1(rf, 1'b1);
    wb(1'b0, `FCD_ADR_DIV, 8'h00);
    chk(q, 32'h00000000);
    wb(1'b1, `FCD_ADR_DIV, 8'h03);
    wb(1'b0, `FCD_ADR_DIV, 8'h00);
    chk(q, 32'h00000083);
    wb(1'b1, `FCD_ADR_DIV, 8'h7f);
    wb(1'b0, `FCD_ADR_DIV, 8'h00);
    chk(q, 32'h00000083);
    per();
    chk(p, 32'd4);
    pe(16'h0003);
    chk1(rf, 1'b0);
    chk(nt, 32'd3);
    mem(1'b1, 1'b0);
    mem(1'b0, 1'b1);
    key(1'b0, 1'b1, KEY);
    chk1(secure, 1'b1);
    key(1'b1, 1'b0, KEY ^ 64'h0000000000000100);
    chk1(secure, 1'b1);
    key(1'b1, 1'b0, KEY);
    chk1(secure, 1'b0);
    wb(1'b0, `FCD_ADR_KCTL, 8'h00);
    chk1(q[1], 1'b0);
    mem(1'b1, 1'b1);
    rst(8'hbf);
    chk1(secure, 1'b1);
    wb(1'b1, `FCD_ADR_DIV, 8'h41);
    per();
    chk(p, 32'd16);
    rst(8'hbf);
    wb(1'b1, `FCD_ADR_DIV, 8'h5f);
    per();
    chk(p, 32'd256);
    rst(8'h43);
    chk1(vre, 1'b0);
    chk1(bke, 1'b0);
    key(1'b1, 1'b0, KEY);
    chk1(secure, 1'b1);
    blank(1'b0);
    chk1(secure, 1'b1);
    blank(1'b1);
    chk1(secure, 1'b0);
    for (c = 0; c < 4; c++)
    begin
      rst({6'h2f, c[1:0]});
      chk1(secure, c != 2);
      wb(1'b0, `FCD_ADR_OPT, 8'h00);
      chk(q, {24'h000000, 2'h2, 4'h0, c[1:0]});
    end
    give_verdict();
  end
endmodule : testbench
`default_nettype wire

// ===== fcd_top.sv
// Flash clock divider, options register and security state
//
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "fcd_params.svh"

// Contract
// RULE_01: Reset clears loaded flag; first divider write sets it regardless of data.
// RULE_02: Divider low seven bits always readable; only first write after reset updates.
// RULE_03: Erase and program refused until loaded flag is set.
// RULE_04: Prescale bit selects bus clock or bus clock over eight.
// RULE_05: Divider divides its input by divisor field plus one.
// RULE_06: Each timing pulse is one flash clock; operations count whole pulses.
// RULE_07: Software keeps flash clock between 150 and 200 kHz.
// RULE_08: Options register is loaded from the nonvolatile byte at reset.
// RULE_09: Options bits five to two always read zero.
// RULE_10: Options register always readable; writes do nothing.
// RULE_11: Software changes options by reprogramming the byte and resetting.
// RULE_12: Key enable low forbids backdoor unlocking.
// RULE_13: Matching eight key bytes in order unlocks until next reset.
// RULE_14: Debug key writes ignored; only secure firmware can unlock.
// RULE_15: Redirect-disable bit high disables vector redirection, low enables it.
// RULE_16: Security code 10 means unsecured; all other codes mean secure.
// RULE_17: While secure, unsecured sources cannot reach RAM or flash contents.
// RULE_18: Code becomes 10 after key unlock or all-erased blank check.
// RULE_19: Blocked accesses drop writes and read back zero.
// RULE_20: Writing divider bit seven never changes the loaded flag directly.
module fcd_top #(
  parameter int PE_CNT_W = `FCD_PE_CNT_W,
  parameter int KEY_BYTES = `FCD_KEY_BYTES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Wishbone slave
  input wire fcd_pkg::fcd_wb_req_s wb_req,
  output fcd_pkg::fcd_wb_rsp_s wb_rsp,
  input wire logic bus_from_debug,
  input wire logic bus_from_secure,
  // Nonvolatile contents
  input wire logic [7:0] nonvolatile_option_byte,
  input wire logic [8*KEY_BYTES-1:0] stored_backdoor_key,
  input wire logic blank_check_done,
  input wire logic blank_all_erased,
  // Program and erase timing
  input wire logic pe_start,
  input wire logic [PE_CNT_W-1:0] pe_pulses,
  output logic flash_clk_tick,
  output logic pe_busy,
  output logic pe_done,
  output logic pe_refused,
  // Memory gate
  input wire logic mem_req,
  input wire logic mem_we_req,
  input wire logic mem_from_unsecure,
  input wire logic [7:0] mem_rdata_raw,
  output logic mem_we,
  output logic [7:0] mem_rdata,
  // Status
  output logic secure,
  output logic vector_redirect_en,
  output logic backdoor_key_enable
);
  import fcd_pkg::*;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic divisor_loaded_flag;
    logic prescale_by_eight;
    logic [`FCD_DIV_FIELD_W-1:0] divisor_field;
    logic opt_valid;
    logic [7:0] flash_options;
    logic key_acc;
    logic key_start;
    fcd_pe_e pe_st;
    logic [PE_CNT_W-1:0] pe_cnt;
    logic pe_done;
    logic pe_refused;
    logic [7:0] mem_rdata;
  } fcd_state_s;

  fcd_state_s s_r;
  fcd_state_s s_nxt;
  logic [1:0] rst_sync_r;
  logic rst_n;
  logic bus_hit;
  logic wr_div;
  logic wr_opt;
  logic wr_kdat;
  logic wr_kctl;
  logic key_wr;
  logic key_match;
  logic tick;
  logic blocked;
  logic [31:0] rd_mux;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_r <= 2'h0;
    else
      rst_sync_r <= {rst_sync_r[0], 1'b1};
  end

  assign rst_n = rst_sync_r[1];

  assign bus_hit = wb_req.cyc && wb_req.stb && !s_r.ack;
  assign wr_div = bus_hit && wb_req.we && wb_req.sel[0]
    && (wb_req.adr == `FCD_ADR_DIV);
  assign wr_opt = bus_hit && wb_req.we
    && (wb_req.adr == `FCD_ADR_OPT); // RULE_10
  assign wr_kdat = bus_hit && wb_req.we && wb_req.sel[0]
    && (wb_req.adr == `FCD_ADR_KDAT);
  assign wr_kctl = bus_hit && wb_req.we && wb_req.sel[0]
    && (wb_req.adr == `FCD_ADR_KCTL);
  // Key bytes count only from secure firmware, never from debug
  assign key_wr = wr_kdat && s_r.key_acc && bus_from_secure
    && !bus_from_debug; // RULE_14

  // Security code 10 is the only unsecured pattern
  assign secure = !s_r.opt_valid
    || (s_r.flash_options[1:0] != `FCD_SEC_UNSECURE); // RULE_16
  assign blocked = secure && mem_from_unsecure; // RULE_17

  always_comb
  begin
    rd_mux = 32'h0;
    case (wb_req.adr)
      `FCD_ADR_DIV:
        rd_mux[7:0] = {s_r.divisor_loaded_flag, s_r.prescale_by_eight,
          s_r.divisor_field}; // RULE_02
      `FCD_ADR_OPT:
        rd_mux[7:0] = {s_r.flash_options[7:6], 4'h0,
          s_r.flash_options[1:0]}; // RULE_09
      `FCD_ADR_KCTL:
        begin
          rd_mux[`FCD_KCTL_ACC_BIT] = s_r.key_acc;
          rd_mux[`FCD_KCTL_SECURE_BIT] = secure;
          rd_mux[`FCD_KCTL_MATCH_BIT] = key_match;
        end
      default:
        rd_mux = 32'h0;
    endcase
  end

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.ack = bus_hit;
    s_nxt.key_start = 1'b0;
    s_nxt.pe_done = 1'b0;
    s_nxt.pe_refused = 1'b0;
    if (bus_hit && !wb_req.we)
      s_nxt.rdata = rd_mux;
    // Options copied from the nonvolatile byte as reset ends
    if (!s_r.opt_valid)
    begin
      s_nxt.opt_valid = 1'b1;
      s_nxt.flash_options = nonvolatile_option_byte; // RULE_08
    end
    // Write-once divider; data bit seven is never stored
    if (wr_div && !s_r.divisor_loaded_flag) // RULE_02
    begin
      s_nxt.divisor_loaded_flag = 1'b1; // RULE_01 RULE_20
      s_nxt.prescale_by_eight = wb_req.dat[`FCD_DIV_PRESC_BIT];
      s_nxt.divisor_field = wb_req.dat[`FCD_DIV_FIELD_W-1:0];
    end
    if (wr_kctl)
    begin
      s_nxt.key_acc = wb_req.dat[`FCD_KCTL_ACC_BIT];
      s_nxt.key_start = wb_req.dat[`FCD_KCTL_ACC_BIT] && !s_r.key_acc;
      // Closing key access checks the entered key
      if (s_r.key_acc && !wb_req.dat[`FCD_KCTL_ACC_BIT] && key_match
        && s_r.flash_options[`FCD_OPT_BACKDOOR_KEY_ENABLE_BIT] && s_r.opt_valid
        && bus_from_secure && !bus_from_debug) // RULE_12 RULE_13 RULE_14
        s_nxt.flash_options[1:0] = `FCD_SEC_UNSECURE; // RULE_18
    end
    if (blank_check_done && blank_all_erased && s_r.opt_valid)
      s_nxt.flash_options[1:0] = `FCD_SEC_UNSECURE; // RULE_18
    // Program and erase timing in whole flash clock pulses
    case (s_r.pe_st)
      FCD_PE_IDLE:
        if (pe_start)
        begin
          if (!s_r.divisor_loaded_flag)
            s_nxt.pe_refused = 1'b1; // RULE_03
          else if (pe_pulses == '0)
            s_nxt.pe_done = 1'b1;
          else
          begin
            s_nxt.pe_st = FCD_PE_RUN;
            s_nxt.pe_cnt = pe_pulses;
          end
        end
      FCD_PE_RUN:
        if (tick) // RULE_06
        begin
          s_nxt.pe_cnt = s_r.pe_cnt - 1'b1;
          if (s_r.pe_cnt == PE_CNT_W'(1))
          begin
            s_nxt.pe_st = FCD_PE_IDLE;
            s_nxt.pe_done = 1'b1;
          end
        end
      default:
        s_nxt.pe_st = FCD_PE_IDLE;
    endcase
    // Blocked reads return zero
    s_nxt.mem_rdata = (mem_req && !blocked) ? mem_rdata_raw : 8'h0; // RULE_19
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_r <= '0;
      s_r.flash_options <= `FCD_OPT_RESET;
      s_r.pe_st <= FCD_PE_IDLE;
    end
    else
      s_r <= s_nxt;
  end

  fcd_clkdiv #(
    .DIV_W(`FCD_DIV_FIELD_W)
  ) u_clkdiv (
    .clk(clk),
    .rst_n(rst_n),
    .en(s_r.divisor_loaded_flag),
    .presc(s_r.prescale_by_eight),
    .divisor(s_r.divisor_field),
    .tick(tick)
  );

  fcd_keycmp #(
    .KEY_BYTES(KEY_BYTES)
  ) u_keycmp (
    .clk(clk),
    .rst_n(rst_n),
    .start(s_r.key_start),
    .wr(key_wr),
    .data(wb_req.dat[7:0]),
    .key(stored_backdoor_key),
    .match(key_match)
  );

  assign wb_rsp.ack = s_r.ack;
  assign wb_rsp.dat = s_r.rdata;
  assign flash_clk_tick = tick;
  assign pe_busy = (s_r.pe_st == FCD_PE_RUN);
  assign pe_done = s_r.pe_done;
  assign pe_refused = s_r.pe_refused;
  assign mem_we = mem_req && mem_we_req && !blocked; // RULE_19
  assign mem_rdata = s_r.mem_rdata;
  assign vector_redirect_en = !s_r.flash_options[`FCD_OPT_NORED_BIT]; // RULE_15
  assign backdoor_key_enable = s_r.flash_options[`FCD_OPT_BACKDOOR_KEY_ENABLE_BIT];

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_first_div_write;
    wr_div && !s_r.divisor_loaded_flag;
  endsequence

  sequence s_key_close;
    wr_kctl && s_r.key_acc && !wb_req.dat[`FCD_KCTL_ACC_BIT];
  endsequence

  a_loaded_first_write: assert property ( // RULE_01
    s_first_div_write |=> s_r.divisor_loaded_flag
      && s_r.divisor_field == $past(wb_req.dat[5:0]))
  else $error("first divider write did not load");

  a_divider_write_once: assert property ( // RULE_02
    wr_div && s_r.divisor_loaded_flag |=> $stable(s_r.divisor_field)
      && $stable(s_r.prescale_by_eight) && s_r.divisor_loaded_flag)
  else $error("divider changed after first write");

  a_pe_refused_unloaded: assert property ( // RULE_03
    pe_start && !pe_busy && !s_r.divisor_loaded_flag
      |=> pe_refused && !pe_busy)
  else $error("program or erase not refused before divider load");

  a_opt_read_zero: assert property ( // RULE_09
    bus_hit && !wb_req.we && wb_req.adr == `FCD_ADR_OPT
      |=> wb_rsp.ack && wb_rsp.dat[5:2] == 4'h0)
  else $error("options unused bits not zero");

  a_opt_write_none: assert property ( // RULE_10
    wr_opt && s_r.opt_valid && !blank_check_done && !wr_kctl
      |=> $stable(s_r.flash_options))
  else $error("options write changed contents");

  a_key_disabled: assert property ( // RULE_12
    s_key_close ##0 !backdoor_key_enable && secure && !blank_check_done
      |=> secure)
  else $error("security dropped with key disabled");

  a_blank_unlock: assert property ( // RULE_18
    blank_check_done && blank_all_erased && s_r.opt_valid
      |=> !secure ##1 !secure)
  else $error("all-erased blank check did not unsecure");

  a_block_read_zero: assert property ( // RULE_19
    mem_req && mem_from_unsecure && secure |=> mem_rdata == 8'h0)
  else $error("blocked read returned data");

  a_pe_count_done: assert property ( // RULE_06
    pe_busy && tick && s_r.pe_cnt == PE_CNT_W'(1) |=> pe_done && !pe_busy)
  else $error("operation did not end on last pulse");

endmodule : fcd_top

`default_nettype wire
